// ===== logic/csc_top.sv
// charger control and status state machine with AXI4-Lite register port
// assumes all sense inputs are comparator levels, brought in through a two-stage synchroniser
`include "csc_regs.svh"
module csc_top
  import csc_pkg::*;
#(
  parameter int HAS_SUPPLY_GOOD = 1,
  parameter logic [31:0] SAFETY_CYCLES = `CSC_SAFETY_CYCLES,
  parameter logic [31:0] FILTER_CYCLES = 32'(`CSC_TERM_FILTER_CYCLES),
  parameter logic [31:0] PG_PULSE_CYCLES = `CSC_PG_PULSE_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire csc_sense_t sense,
  output csc_ctl_t ctl,
  output logic charge_status_first_o,
  output logic charge_status_first_oe_n,
  output logic charge_status_second_o,
  output logic charge_status_second_oe_n,
  output logic supply_good_output_o,
  output logic supply_good_output_oe_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  csc_state_all_t st_reg, st_next;

  // decode used by both write and read paths
  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a == `CSC_CTRL_OFFSET) || (a == `CSC_STATUS_OFFSET) ||
      (a == `CSC_TIMER_OFFSET) || (a == `CSC_CURRENT_OFFSET);
  endfunction

  // merge write data by byte strobes
  function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    strobe_merge = r;
  endfunction

  // open-drain enables: low means pin pulled low; pins never drive high
  assign charge_status_first_o = 1'b0;
  assign charge_status_second_o = 1'b0;
  assign supply_good_output_o = 1'b0;
  assign charge_status_first_oe_n = st_reg.oe_n[0];
  assign charge_status_second_oe_n = st_reg.oe_n[1];
  assign supply_good_output_oe_n = st_reg.oe_n[2];
  assign ctl = st_reg.ctl;

  assign s_axi_awready = !st_reg.awa && !st_reg.bvalid;
  assign s_axi_wready = !st_reg.wda && !st_reg.bvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_arready = !st_reg.rvalid;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;

  always_comb begin
    csc_sense_t s;
    logic enabled;
    logic timer_on;
    logic [15:0] sel_ma;
    logic [31:0] status_word;
    st_next = st_reg;
    status_word = {20'h0, st_reg.suspended, st_reg.oe_n, 4'(st_reg.state), 4'h0};
    // two-stage sync: only s2 is looked at by the logic
    st_next.s1 = sense;
    st_next.s2 = st_reg.s1;
    s = st_reg.s2;
    // hi-z on usb select with a usb source, open programming input or forced disable all stop the device
    enabled = !s.adapter_set_open && !s.adapter_set_high &&
      !(s.usb_source && s.usb_select_hiz) &&
      !st_reg.ctrl[`CSC_CTRL_FORCE_DIS_BIT];
    timer_on = (HAS_SUPPLY_GOOD != 0) ? st_reg.ctrl[`CSC_CTRL_TIMER_EN_BIT]
                                      : !s.timer_enable_n;
    sel_ma = s.usb_select_level ? `CSC_USB_HIGH_MA : `CSC_USB_LOW_MA;

    // state machine
    case (st_reg.state)
      CSC_SHUTDOWN: begin
        if (s.supply_ok && s.supply_above_bat) begin
          st_next.state = CSC_STANDBY;
        end
      end
      CSC_STANDBY: begin
        if (!s.battery_present && s.thermistor_sense_input_above_test) begin
          st_next.state = CSC_SYSTEST;
        end else if (enabled && s.battery_present) begin
          st_next.state = s.bat_below_precond ? CSC_PRECOND : CSC_CC;
          st_next.timer = 32'h0;
          st_next.suspended = 1'b0;
        end
      end
      CSC_PRECOND, CSC_CC, CSC_CV: begin
        // temperature watched throughout charge; out of window freezes timer, filter and state, but disable, battery removal or supply loss still exit
        if (!s.thermistor_sense_input_in_window) begin
          st_next.suspended = 1'b1;
        end else begin
          st_next.suspended = 1'b0;
          if (timer_on) begin
            st_next.timer = st_reg.timer + 32'h1;
          end
          if (st_reg.state == CSC_PRECOND && !s.bat_below_precond) begin
            st_next.state = CSC_CC;
            st_next.timer = 32'h0;
          end else if (st_reg.state == CSC_CC && s.bat_at_reg) begin
            st_next.state = CSC_CV;
          end
          if (st_reg.state == CSC_CV && s.low_current) begin
            st_next.filter = st_reg.filter + 32'h1;
            if (st_reg.filter + 32'h1 >= FILTER_CYCLES) begin
              st_next.state = CSC_COMPLETE;
              st_next.filter = 32'h0;
            end
          end else begin
            st_next.filter = 32'h0;
          end
          if (timer_on && st_reg.timer >= SAFETY_CYCLES - 32'h1 &&
              st_reg.state != CSC_PRECOND) begin
            st_next.state = CSC_TIMER_FAULT;
          end
        end
        if (!enabled || !s.battery_present) begin
          st_next.state = CSC_STANDBY;
          st_next.suspended = 1'b0;
        end
      end
      CSC_COMPLETE: begin
        if (!enabled || !s.battery_present) begin
          st_next.state = CSC_STANDBY;
        end else if (s.bat_below_recharge) begin
          st_next.state = CSC_CC;
          st_next.timer = 32'h0;
        end
      end
      CSC_TEMP_FAULT: begin
        st_next.state = CSC_STANDBY;
      end
      CSC_TIMER_FAULT: begin
        if (!enabled || !s.battery_present) begin
          st_next.state = CSC_STANDBY;
        end
      end
      CSC_SYSTEST: begin
        if (!s.thermistor_sense_input_above_test) begin
          st_next.state = CSC_STANDBY;
        end
      end
      default: begin
        st_next.state = CSC_SHUTDOWN;
      end
    endcase
    // supply loss from any state is shutdown, which also clears test mode
    if (!s.supply_ok || !s.supply_above_bat) begin
      st_next.state = CSC_SHUTDOWN;
      st_next.suspended = 1'b0;
    end

    // supply good pulse timebase while battery presence is unresolved
    if (st_reg.pg_count >= PG_PULSE_CYCLES - 32'h1) begin
      st_next.pg_count = 32'h0;
      st_next.pg_pulse = !st_reg.pg_pulse;
    end else begin
      st_next.pg_count = st_reg.pg_count + 32'h1;
    end

    // power stage controls, registered from the next state
    st_next.ctl.pass_on = (st_next.state inside {CSC_PRECOND, CSC_CC, CSC_CV}) &&
      !st_next.suspended;
    st_next.ctl.regulator_mode = (st_next.state == CSC_SYSTEST);
    st_next.ctl.thermistor_bias_current =
      !(st_next.state inside {CSC_SHUTDOWN, CSC_STANDBY, CSC_SYSTEST});
    st_next.ctl.thermistor_sense_input_pulldown = (st_next.state inside {CSC_STANDBY, CSC_SYSTEST});
    st_next.ctl.charge_ma = sel_ma;
    st_next.ctl.precond_ma = sel_ma / 16'(`CSC_PRECOND_DIV);
    st_next.ctl.term_ma = sel_ma / 16'(`CSC_TERM_DIV);

    // status pins, oe_n low means sinking
    case (st_next.state)
      CSC_SHUTDOWN: st_next.oe_n = 3'b111;
      CSC_STANDBY, CSC_TEMP_FAULT, CSC_TIMER_FAULT: st_next.oe_n = 3'b011;
      CSC_PRECOND, CSC_CC, CSC_CV: st_next.oe_n = 3'b010;
      CSC_COMPLETE: st_next.oe_n = 3'b001;
      CSC_SYSTEST: st_next.oe_n = 3'b000;
      default: st_next.oe_n = 3'b111;
    endcase
    // follow the next suspend flag so the pins move in the same cycle as pass_on
    if (st_next.suspended && st_next.state != CSC_SHUTDOWN) begin
      st_next.oe_n[1:0] = 2'b11; // temperature fault shows as both floating
    end
    if (HAS_SUPPLY_GOOD == 0) begin
      st_next.oe_n[2] = 1'b1;
    end else if (st_next.state != CSC_SHUTDOWN && st_next.state != CSC_SYSTEST &&
                 !s.supply_above_reg_margin && !s.battery_present) begin
      // test mode has no battery by definition, so it is kept out of the pulse
      st_next.oe_n[2] = st_reg.pg_pulse;
    end

    // AXI4-Lite write: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_next.awa = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_next.wda = 1'b1;
      st_next.wdata = strobe_merge(st_reg.ctrl, s_axi_wdata, s_axi_wstrb);
    end
    if (st_reg.awa && st_reg.wda) begin
      st_next.awa = 1'b0;
      st_next.wda = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = addr_hit(st_reg.awaddr) ? 2'b00 : 2'b10;
      if (st_reg.awaddr == `CSC_CTRL_OFFSET) begin
        st_next.ctrl = {30'h0, st_reg.wdata[1:0]};
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // read: one cycle to answer, unmapped gives slverr and zero
    if (s_axi_arvalid && s_axi_arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp = addr_hit(s_axi_araddr) ? 2'b00 : 2'b10;
      case (s_axi_araddr)
        `CSC_CTRL_OFFSET: st_next.rdata = st_reg.ctrl;
        `CSC_STATUS_OFFSET: st_next.rdata = status_word;
        `CSC_TIMER_OFFSET: st_next.rdata = st_reg.timer;
        `CSC_CURRENT_OFFSET: st_next.rdata = {st_reg.ctl.term_ma, st_reg.ctl.charge_ma};
        default: st_next.rdata = 32'h0;
      endcase
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  // single state register; reset gives shutdown with all pins floating
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
      st_reg.state <= CSC_SHUTDOWN;
      st_reg.ctrl <= `CSC_CTRL_RESET;
      st_reg.oe_n <= 3'b111;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule

// ===== logic/csc_regs.svh
// constants for the charger state and status controller: offsets, fields, resets, timings
// assumes a 100 MHz clock and a 32-bit AXI4-Lite register port
// Function
// - while charging, keep watching the thermistor window comparator result
// - temperature outside the window during charging suspends charge at once
// - temperature suspend turns the pass transistor off and freezes the timer
// - temperature back in window resumes charge, timer continues from frozen count
// - thermistor input above supply margin with no battery enters system test mode
// - in system test mode regulate output voltage, limit to fast charge current
// - thermistor bias current off in shutdown, standby and system test
// - thermistor pull-down on only in standby and system test
// - leave system test when thermistor released or input power cycled
// - charge status outputs only sink low or float, never drive high
// - shutdown floats all; standby and faults float both status, supply good low
// - charging: first low; complete: second low; system test: all low
// - usb select low picks low current limit, high picks high limit
// - precondition and termination currents are fixed fractions of chosen current
// - supply good only sinks or floats; low when supply above lockout and battery
// - supply above lockout but below regulation margin pulses supply good; the code pulses it only with no battery and outside system test
// - timer enable low enables safety timer, high disables it; with HAS_SUPPLY_GOOD set the code uses control register bit 0
// - floating programming input or adapter set high disables device, ends charge
// - re-enabling programming inputs starts new charge; disabling ends any charge
// - termination needs low-current result held through a filter interval
// - in charge complete, battery below recharge threshold starts new cycle
// - safety timer expiry flags timer fault, held until battery removed or disabled; the code never flags it in precondition
// - high impedance on usb select suspends or disables charging; the code disables charging only with a usb source
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH
`define CSC_CTRL_OFFSET 12'h000
`define CSC_STATUS_OFFSET 12'h004
`define CSC_TIMER_OFFSET 12'h008
`define CSC_CURRENT_OFFSET 12'h00c
`define CSC_CTRL_RESET 32'h0000_0001
`define CSC_CTRL_TIMER_EN_BIT 0
`define CSC_CTRL_FORCE_DIS_BIT 1
`define CSC_TERM_FILTER_US 1000
`define CSC_CLOCK_MHZ 100
`define CSC_TERM_FILTER_CYCLES (`CSC_TERM_FILTER_US * `CSC_CLOCK_MHZ)
`define CSC_SAFETY_CYCLES 32'd360000000
`define CSC_PG_PULSE_CYCLES 32'd50000
`define CSC_USB_LOW_MA 16'd100
`define CSC_USB_HIGH_MA 16'd500
`define CSC_PRECOND_DIV 4'd10
`define CSC_TERM_DIV 4'd10
`endif

// ===== logic/csc_pkg.sv
// types for the charger state and status controller
// assumes csc_regs.svh supplies the numeric constants
package csc_pkg;
  typedef enum logic [3:0] {
    CSC_SHUTDOWN, CSC_STANDBY, CSC_PRECOND, CSC_CC, CSC_CV,
    CSC_COMPLETE, CSC_TEMP_FAULT, CSC_TIMER_FAULT, CSC_SYSTEST
  } csc_state_t;
  // analog comparator results, raw from the pins
  typedef struct packed {
    logic supply_ok;
    logic supply_above_bat;
    logic supply_above_reg_margin;
    logic battery_present;
    logic thermistor_sense_input_in_window;
    logic thermistor_sense_input_above_test;
    logic bat_below_precond;
    logic bat_at_reg;
    logic bat_below_recharge;
    logic low_current;
    logic adapter_set_open;
    logic adapter_set_high;
    logic usb_select_level;
    logic usb_select_hiz;
    logic usb_source;
    logic timer_enable_n;
  } csc_sense_t;
  // analog control outputs toward the power stage
  typedef struct packed {
    logic pass_on;
    logic regulator_mode;
    logic thermistor_bias_current;
    logic thermistor_sense_input_pulldown;
    logic [15:0] charge_ma;
    logic [15:0] precond_ma;
    logic [15:0] term_ma;
  } csc_ctl_t;
  typedef struct packed {
    csc_state_t state;
    csc_sense_t s1;
    csc_sense_t s2;
    logic [31:0] timer;
    logic [31:0] filter;
    logic [31:0] pg_count;
    logic pg_pulse;
    logic suspended;
    logic [31:0] ctrl;
    logic awa, wda;
    logic [11:0] awaddr;
    logic [31:0] wdata;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    csc_ctl_t ctl;
    logic [2:0] oe_n;
  } csc_state_all_t;
endpackage

// ===== verif/csc_props.sv
// port checker for the charger control and status block
// assumes it is bound into csc_top and sees one clock domain
module csc_props
  import csc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire csc_sense_t sense,
  input wire csc_ctl_t ctl,
  input wire logic charge_status_first_o,
  input wire logic charge_status_first_oe_n,
  input wire logic charge_status_second_o,
  input wire logic charge_status_second_oe_n,
  input wire logic supply_good_output_o,
  input wire logic supply_good_output_oe_n,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pins;
  logic hi;
  // enables in first, second, supply good order; hi means some pin could source current
  assign pins = {charge_status_first_oe_n, charge_status_second_oe_n, supply_good_output_oe_n};
  assign hi = charge_status_first_o | charge_status_second_o | supply_good_output_o;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  never_high_a: assert property (!hi)
    else $error("status pin drives high");
  charge_first_low_a: assert property (
    ctl.pass_on && !ctl.regulator_mode |-> pins[2:1] == 2'b01)
    else $error("charging pins wrong");
  test_all_low_a: assert property (ctl.regulator_mode |-> pins == 3'b000)
    else $error("test mode pins not low");
  test_bias_a: assert property (
    ctl.regulator_mode |-> ctl.thermistor_sense_input_pulldown && !ctl.thermistor_bias_current)
    else $error("test mode bias wrong");
  bias_excl_a: assert property (
    ctl.thermistor_sense_input_pulldown |-> !ctl.thermistor_bias_current)
    else $error("bias and pulldown both on");
  current_ratio_a: assert property (
    ctl.precond_ma == ctl.charge_ma / 16'd10 && ctl.term_ma == ctl.charge_ma / 16'd10)
    else $error("current ratio wrong");
  usb_level_a: assert property (
    ctl.charge_ma == 16'd0 || ctl.charge_ma == 16'd100 || ctl.charge_ma == 16'd500)
    else $error("charge current level wrong");
  temp_stop_a: assert property (
    ctl.pass_on && !ctl.regulator_mode && !sense.thermistor_sense_input_in_window |-> ##[1:4] !ctl.pass_on)
    else $error("no suspend on temperature");
  supply_loss_a: assert property (!sense.supply_ok [*4] |=> pins == 3'b111)
    else $error("supply loss pins not floating");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  cover property (ctl.regulator_mode);
  cover property (ctl.pass_on ##1 !ctl.pass_on);
  cover property (pins == 3'b100);
endmodule

// ===== verif/csc_host.sv
// host or led side of the open-drain status lines
// assumes pull-ups to the input rail on all three lines
module csc_host (
  input wire logic [2:0] drv_oe_n,
  input wire logic [2:0] drv_o,
  output logic [2:0] line
);
  timeunit 1ns;
  timeprecision 1ps;
  // a released line reads the pull-up, never a stale level
  assign line = drv_oe_n | drv_o;
endmodule

// ===== verif/csc_top_tb.sv
// self-checking bench for the charger control block
// assumes short counts set below and the pull-up host model on the status lines
`include "csc_regs.svh"
module csc_top_tb
  import csc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 0, rst_n = 0, ha, hb;
  csc_sense_t sn = '0, s;
  csc_ctl_t ctl;
  logic [2:0] oe_n, o, line;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata, v, tfz;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, hw;
  logic [1:0] bresp, rresp, r;
  int n_fail = 0, n_compared = 0, sel, cm;
  always #5 clock = ~clock;
  csc_top #(.HAS_SUPPLY_GOOD(1), .SAFETY_CYCLES(32'd200), .FILTER_CYCLES(32'd20),
    .PG_PULSE_CYCLES(32'd8)) uut (.clock, .rst_n, .sense(sn), .ctl,
    .charge_status_first_o(o[2]), .charge_status_first_oe_n(oe_n[2]),
    .charge_status_second_o(o[1]), .charge_status_second_oe_n(oe_n[1]),
    .supply_good_output_o(o[0]), .supply_good_output_oe_n(oe_n[0]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  csc_host host (.drv_oe_n(oe_n), .drv_o(o), .line);
  task end_sim();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task put();
    @(posedge clock);
    sn <= s;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge clock);
  endtask
  // handshakes are judged at the falling edge, where ready has settled for the next rise
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(negedge clock);
      {ha, hw, hb, r} = {awready, wready, bvalid, bresp};
      @(posedge clock);
      if (ha) awvalid <= 0;
      if (hw) wvalid <= 0;
    end while (!hb);
    bready <= 0;
  endtask
  task rd(input logic [11:0] a);
    @(posedge clock);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do begin
      @(negedge clock);
      {ha, hb, v, r} = {arready, rvalid, rdata, rresp};
      @(posedge clock);
      if (ha) arvalid <= 0;
    end while (!hb);
    rready <= 0;
  endtask
  // expected pin enables {first, second, supply good} for each charge state
  function automatic logic [2:0] pin_exp(input int st);
    case (st)
      0: return 3'b111;
      2, 3, 4: return 3'b010;
      5: return 3'b100;
      8: return 3'b000;
      default: return 3'b110;
    endcase
  endfunction
  task step(input int st, input logic susp);
    wait_n(8);
    chk("pins", line, susp ? 3'b110 : pin_exp(st));
    rd(`CSC_STATUS_OFFSET);
    chk("state", {v[11], v[7:4]}, {susp, 4'(st)});
  endtask
  initial begin
    sel = $urandom(32'h77a0);
    s = '0;
    wait_n(12);
    rst_n <= 1;
    step(0, 0);
    rd(`CSC_CTRL_OFFSET);
    chk("ctrl", v, `CSC_CTRL_RESET);
    wr(`CSC_CTRL_OFFSET, 32'hffff_fffe);
    rd(`CSC_CTRL_OFFSET);
    chk("ctrl", v, 32'h2);
    wr(12'h010, 32'h1);
    chk("wresp", r, 2'b10);
    rd(12'h010);
    chk("rdata", v, 32'h0);
    chk("rresp", r, 2'b10);
    wr(`CSC_CTRL_OFFSET, 32'h0);
    $display("test regs finished");
    sel = $urandom() % 2;
    cm = sel ? `CSC_USB_HIGH_MA : `CSC_USB_LOW_MA;
    {s.supply_ok, s.supply_above_bat, s.supply_above_reg_margin, s.battery_present} = 4'hf;
    {s.thermistor_sense_input_in_window, s.bat_below_precond, s.usb_source, s.usb_select_level} = {3'b111, sel[0]};
    put();
    step(2, 0);
    chk("bias", ctl.thermistor_bias_current, 1);
    chk("charge_ma", ctl.charge_ma, cm);
    rd(`CSC_CURRENT_OFFSET);
    chk("currents", v, {16'(cm / 10), 16'(cm)});
    s.bat_below_precond = 0;
    put();
    step(3, 0);
    wr(`CSC_CTRL_OFFSET, 32'h1);
    s.thermistor_sense_input_in_window = 0;
    put();
    step(3, 1);
    chk("pass", ctl.pass_on, 0);
    rd(`CSC_TIMER_OFFSET);
    tfz = v;
    wait_n(20);
    rd(`CSC_TIMER_OFFSET);
    chk("frozen", v, tfz);
    s.thermistor_sense_input_in_window = 1;
    put();
    step(3, 0);
    rd(`CSC_TIMER_OFFSET);
    chk("resumed", v > tfz, 1);
    $display("test temperature finished");
    wait_n(260);
    step(7, 0);
    s.battery_present = 0;
    put();
    step(1, 0);
    $display("test timer finished");
    wr(`CSC_CTRL_OFFSET, 32'h0);
    s.battery_present = 1;
    put();
    step(3, 0);
    rd(`CSC_TIMER_OFFSET);
    chk("timer_off", v, 32'h0);
    s.bat_at_reg = 1;
    put();
    step(4, 0);
    s.low_current = 1;
    put();
    wait_n(5);
    s.low_current = 0;
    put();
    step(4, 0);
    s.low_current = 1;
    put();
    wait_n(30);
    step(5, 0);
    {s.bat_below_recharge, s.bat_at_reg, s.low_current} = 3'b100;
    put();
    wait_n(8);
    chk("recharge", line, 3'b010);
    s.bat_below_recharge = 0;
    $display("test cycle finished");
    // adapter set high, open programming input and usb hi-z each, then re-enabling, must stop and restart the charge
    for (int k = 0; k < 3; k++) begin
      {s.adapter_set_high, s.adapter_set_open, s.usb_select_hiz} = 3'b100 >> k;
      put();
      wait_n(8);
      chk("pass_off", {ctl.pass_on, line[2]}, 2'b01);
      {s.adapter_set_high, s.adapter_set_open, s.usb_select_hiz} = 3'b000;
      put();
      wait_n(8);
      chk("pass_on", ctl.pass_on, 1);
    end
    $display("test disable finished");
    {s.battery_present, s.thermistor_sense_input_in_window, s.thermistor_sense_input_above_test} = 3'b001;
    put();
    step(8, 0);
    v = 32'({ctl.regulator_mode, ctl.thermistor_bias_current, ctl.thermistor_sense_input_pulldown});
    chk("reg_mode", v, 32'h5);
    {s.thermistor_sense_input_in_window, s.thermistor_sense_input_above_test} = 2'b10;
    put();
    step(1, 0);
    chk("standby", {ctl.thermistor_bias_current, ctl.thermistor_sense_input_pulldown}, 2'b01);
    // low supply margin with no battery: supply good is a square wave, half low in 16 cycles
    s.supply_above_reg_margin = 0;
    put();
    wait_n(4);
    cm = 0;
    repeat (16) begin
      @(posedge clock);
      cm += line[0];
    end
    chk("pg_pulse", cm, 8);
    s.supply_ok = 0;
    put();
    step(0, 0);
    chk("shut_bias", ctl.thermistor_bias_current, 0);
    $display("test power finished");
    end_sim();
  end
  // the tests take well under a thousand cycles; this limit of 20000 cycles leaves wide margin
  initial begin
    #(20000 * 10);
    n_fail++;
    end_sim();
  end
endmodule
bind csc_top csc_props u_props (.clock, .rst_n, .sense, .ctl, .charge_status_first_o,
  .charge_status_first_oe_n, .charge_status_second_o, .charge_status_second_oe_n,
  .supply_good_output_o, .supply_good_output_oe_n, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .s_axi_bvalid, .s_axi_bready);
